// [include/serial_link_ctrl_pkg.sv]
package serial_link_ctrl_pkg;

    // ----------------------------------------------------------------
    // Register word indices
    // ----------------------------------------------------------------
    localparam logic [9:0] IDX_LINK_ENABLE = 10'h200;
    localparam logic [9:0] IDX_SW_SYNC = 10'h203;
    localparam logic [9:0] IDX_LINK_CONTROL = 10'h204;
    localparam logic [9:0] IDX_TEST_SELECT = 10'h205;
    localparam logic [9:0] IDX_ENCODING = 10'h210;
    localparam logic [9:0] IDX_STATUS = 10'h211;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_LINK_ENABLE = 8'h01;
    localparam logic [7:0] RST_SW_SYNC = 8'h01;
    localparam logic [7:0] RST_LINK_CONTROL = 8'h03;
    localparam logic [7:0] RST_TEST_SELECT = 8'h00;
    localparam logic [7:0] RST_ENCODING = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int POS_LINK_ENABLE = 0;
    localparam int POS_SW_SYNC = 0;
    localparam int POS_RANDOMIZER = 0;
    localparam int POS_SAMPLE_FORMAT = 1;
    localparam int POS_SYNC_SEL_LO = 2;
    localparam int POS_UPPER_LANES = 4;
    localparam int POS_ENC_66B = 0;

    // ----------------------------------------------------------------
    // Sync source codes and lane groups
    // ----------------------------------------------------------------
    localparam logic [1:0] SYNC_SRC_DEDICATED = 2'h0;
    localparam logic [1:0] SYNC_SRC_TIMESTAMP = 2'h1;
    localparam logic [1:0] SYNC_SRC_NONE = 2'h2;
    localparam logic [7:0] LANES_LOWER = 8'h0f;
    localparam logic [7:0] LANES_UPPER = 8'hf0;
    localparam logic [7:0] LANES_OFF = 8'h00;

    // ----------------------------------------------------------------
    // Pattern select codes
    // ----------------------------------------------------------------
    localparam logic [4:0] PAT_NORMAL = 5'h00;
    localparam logic [4:0] PAT_PRBS7 = 5'h01;
    localparam logic [4:0] PAT_PRBS15 = 5'h02;
    localparam logic [4:0] PAT_PRBS23 = 5'h03;
    localparam logic [4:0] PAT_RAMP = 5'h04;
    localparam logic [4:0] PAT_TRANSPORT = 5'h05;
    localparam logic [4:0] PAT_D21_5 = 5'h06;
    localparam logic [4:0] PAT_K28_5 = 5'h07;
    localparam logic [4:0] PAT_REP_ALIGN = 5'h08;
    localparam logic [4:0] PAT_MOD_RPAT = 5'h09;
    localparam logic [4:0] PAT_HOLD_LOW = 5'h0a;
    localparam logic [4:0] PAT_HOLD_HIGH = 5'h0b;
    localparam logic [4:0] PAT_PRBS9 = 5'h0d;
    localparam logic [4:0] PAT_PRBS31 = 5'h0e;
    localparam logic [4:0] PAT_CLOCK = 5'h0f;
    localparam logic [4:0] PAT_K28_7 = 5'h10;
    localparam logic [15:0] CLOCK_PATTERN_WORD = 16'h00ff;

    // Decoded pattern kind presented to the serializer
    typedef enum logic [4:0] {
        KIND_NORMAL, KIND_PRBS7, KIND_PRBS9, KIND_PRBS15, KIND_PRBS23, KIND_PRBS31,
        KIND_RAMP, KIND_TRANSPORT, KIND_D21_5, KIND_K28_5, KIND_REP_ALIGN,
        KIND_MOD_RPAT, KIND_HOLD_LOW, KIND_HOLD_HIGH, KIND_CLOCK, KIND_K28_7,
        KIND_UNDEFINED
    } pattern_kind_e;

endpackage

// [include/lane_ctrl_if.sv]
`timescale 1ns/1ps
`default_nettype none

// Control from the register block to one link's lane mapper
interface lane_ctrl_if;
    logic link_enable;
    logic upper_lane_map;
    logic [7:0] lane_power;

    modport ctrl (
        output link_enable,
        output upper_lane_map,
        input lane_power
    );
    modport mapper (
        input link_enable,
        input upper_lane_map,
        output lane_power
    );
endinterface

`default_nettype wire

// [core/lane_mapper.sv]
`timescale 1ns/1ps
`default_nettype none

module lane_mapper (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    lane_ctrl_if.mapper lanes
);

    logic [7:0] power_reg;
    logic [7:0] power_next;

    // ----------------------------------------------------------------
    // Lane power map
    // ----------------------------------------------------------------

    // Pick the active lane group; everything else is powered down
    always_comb begin
        if (!lanes.link_enable) begin
            power_next = serial_link_ctrl_pkg::LANES_OFF;
        end else if (lanes.upper_lane_map) begin
            power_next = serial_link_ctrl_pkg::LANES_UPPER;
        end else begin
            power_next = serial_link_ctrl_pkg::LANES_LOWER;
        end
    end

    // Register the map
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_reg <= serial_link_ctrl_pkg::LANES_OFF;
        end else begin
            power_reg <= power_next;
        end
    end

    assign lanes.lane_power = power_reg;

endmodule

`default_nettype wire

// [core/serial_link_sync_lane_test_ctrl.sv]
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module serial_link_sync_lane_test_ctrl (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Sync pins, active low
    input wire logic dedicated_sync_pin_n,
    input wire logic timestamp_pin_n,
    // Link controls
    output logic sync_request,
    output logic link_block_reset,
    output logic link_clock_enable,
    output logic [7:0] lane_power_a,
    output logic [7:0] lane_power_b,
    output logic sample_twos_complement,
    output logic randomizer_active,
    output logic [4:0] link_pattern_select,
    output logic [4:0] pattern_kind,
    output logic [15:0] clock_pattern_word
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] link_enable_reg, link_enable_next;
    logic [7:0] software_sync_request_reg, software_sync_request_next;
    logic [7:0] link_control_reg, link_control_next;
    logic [7:0] link_test_select_reg, link_test_select_next;
    logic [7:0] link_encoding_reg, link_encoding_next;
    logic wr_pend_reg, wr_pend_next;
    logic [9:0] wr_idx_reg, wr_idx_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic sync_request_reg, sync_request_next;
    logic block_reset_reg, block_reset_next;
    logic clock_enable_reg, clock_enable_next;
    logic twos_reg, twos_next;
    logic randomizer_reg, randomizer_next;
    logic [4:0] pattern_kind_reg, pattern_kind_next;
    logic addr_ok;
    logic [9:0] addr_idx;
    logic take;
    logic link_enable;
    logic [1:0] sync_sel;
    logic pin_request;
    logic [7:0] read_value;
    logic [7:0] status_value;

    lane_ctrl_if lanes_a ();
    lane_ctrl_if lanes_b ();

    // ----------------------------------------------------------------
    // Bus address phase
    // ----------------------------------------------------------------

    // Word index of the access; upper bits must be zero
    assign addr_idx = haddr[11:2];
    assign addr_ok = (haddr[31:12] == 20'h00000);
    assign take = hsel && htrans[1] && hready;
    assign link_enable = link_enable_reg[serial_link_ctrl_pkg::POS_LINK_ENABLE];
    assign sync_sel = link_control_reg[serial_link_ctrl_pkg::POS_SYNC_SEL_LO +: 2];

    // Status word shows the block's live state
    assign status_value = {lane_power_b[4], lane_power_a[0], pattern_kind_reg == 5'h00,
        randomizer_reg, block_reset_reg, pin_request, !sync_request_reg, clock_enable_reg};

    // Register read mux on next values, so a read right after
    // a write to the same word returns the new data
    always_comb begin
        read_value = 8'h00;
        if (addr_ok) begin
            case (addr_idx)
                serial_link_ctrl_pkg::IDX_LINK_ENABLE: read_value = link_enable_next;
                serial_link_ctrl_pkg::IDX_SW_SYNC: read_value = software_sync_request_next;
                serial_link_ctrl_pkg::IDX_LINK_CONTROL: read_value = link_control_next;
                serial_link_ctrl_pkg::IDX_TEST_SELECT: read_value = link_test_select_next;
                serial_link_ctrl_pkg::IDX_ENCODING: read_value = link_encoding_next;
                serial_link_ctrl_pkg::IDX_STATUS: read_value = status_value;
                default: read_value = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Bus state and register file
    // ----------------------------------------------------------------

    // Latch writes in the address phase, commit them in the data phase
    always_comb begin
        wr_pend_next = take && hwrite && addr_ok;
        wr_idx_next = take ? addr_idx : wr_idx_reg;
        hrdata_next = hrdata_reg;
        if (take && !hwrite) begin
            hrdata_next = {24'h000000, read_value};
            // Status and unmapped words read live state or zero,
            // never the data of a write still in its data phase
        end
        link_enable_next = link_enable_reg;
        software_sync_request_next = software_sync_request_reg;
        link_control_next = link_control_reg;
        link_test_select_next = link_test_select_reg;
        link_encoding_next = link_encoding_reg;
        // Status and unmapped words drop the write
        if (wr_pend_reg) begin
            case (wr_idx_reg)
                serial_link_ctrl_pkg::IDX_LINK_ENABLE: link_enable_next = hwdata[7:0];
                serial_link_ctrl_pkg::IDX_SW_SYNC: software_sync_request_next = hwdata[7:0];
                serial_link_ctrl_pkg::IDX_LINK_CONTROL: link_control_next = hwdata[7:0];
                serial_link_ctrl_pkg::IDX_TEST_SELECT: link_test_select_next = hwdata[7:0];
                serial_link_ctrl_pkg::IDX_ENCODING: link_encoding_next = hwdata[7:0];
                default: link_enable_next = link_enable_reg;
            endcase
        end
    end

    // Register the bus state and the register file
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 10'h000;
            hrdata_reg <= 32'h00000000;
            link_enable_reg <= serial_link_ctrl_pkg::RST_LINK_ENABLE;
            software_sync_request_reg <= serial_link_ctrl_pkg::RST_SW_SYNC;
            link_control_reg <= serial_link_ctrl_pkg::RST_LINK_CONTROL;
            link_test_select_reg <= serial_link_ctrl_pkg::RST_TEST_SELECT;
            link_encoding_reg <= serial_link_ctrl_pkg::RST_ENCODING;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_idx_reg <= wr_idx_next;
            hrdata_reg <= hrdata_next;
            link_enable_reg <= link_enable_next;
            software_sync_request_reg <= software_sync_request_next;
            link_control_reg <= link_control_next;
            link_test_select_reg <= link_test_select_next;
            link_encoding_reg <= link_encoding_next;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    // ----------------------------------------------------------------
    // Sync request path
    // ----------------------------------------------------------------

    // Pins are active low; the selected pin stuck low keeps the request up
    // Pick the sync pin; reserved code 3 behaves as no pin
    always_comb begin
        case (sync_sel)
            serial_link_ctrl_pkg::SYNC_SRC_DEDICATED: pin_request = !dedicated_sync_pin_n;
            serial_link_ctrl_pkg::SYNC_SRC_TIMESTAMP: pin_request = !timestamp_pin_n;
            serial_link_ctrl_pkg::SYNC_SRC_NONE: pin_request = 1'b0;
            default: pin_request = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Link control outputs
    // ----------------------------------------------------------------

    // Derive the link controls from the registers; sync request also takes the selected pin
    always_comb begin
        // Pin or software can each force the request
        sync_request_next = pin_request
            || !software_sync_request_reg[serial_link_ctrl_pkg::POS_SW_SYNC];
        block_reset_next = !link_enable;
        clock_enable_next = link_enable;
        twos_next = link_control_reg[serial_link_ctrl_pkg::POS_SAMPLE_FORMAT];
        randomizer_next = link_encoding_reg[serial_link_ctrl_pkg::POS_ENC_66B]
            || link_control_reg[serial_link_ctrl_pkg::POS_RANDOMIZER];
        // Codes 7, 8, 9 and 16 only make sense in 8b/10b modes
        case (link_test_select_reg[4:0])
            serial_link_ctrl_pkg::PAT_NORMAL:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_NORMAL;
            serial_link_ctrl_pkg::PAT_PRBS7:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_PRBS7;
            serial_link_ctrl_pkg::PAT_PRBS15:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_PRBS15;
            serial_link_ctrl_pkg::PAT_PRBS23:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_PRBS23;
            serial_link_ctrl_pkg::PAT_RAMP:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_RAMP;
            serial_link_ctrl_pkg::PAT_TRANSPORT:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_TRANSPORT;
            serial_link_ctrl_pkg::PAT_D21_5:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_D21_5;
            serial_link_ctrl_pkg::PAT_K28_5:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_K28_5;
            serial_link_ctrl_pkg::PAT_REP_ALIGN:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_REP_ALIGN;
            serial_link_ctrl_pkg::PAT_MOD_RPAT:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_MOD_RPAT;
            serial_link_ctrl_pkg::PAT_HOLD_LOW:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_HOLD_LOW;
            serial_link_ctrl_pkg::PAT_HOLD_HIGH:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_HOLD_HIGH;
            serial_link_ctrl_pkg::PAT_PRBS9:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_PRBS9;
            serial_link_ctrl_pkg::PAT_PRBS31:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_PRBS31;
            serial_link_ctrl_pkg::PAT_CLOCK:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_CLOCK;
            serial_link_ctrl_pkg::PAT_K28_7:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_K28_7;
            default:
                pattern_kind_next = serial_link_ctrl_pkg::KIND_UNDEFINED;
        endcase
    end

    // Register the link controls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Outputs start at what the register defaults imply, except block reset starts set and clock enable clear
            sync_request_reg <= 1'b0;
            block_reset_reg <= 1'b1;
            clock_enable_reg <= 1'b0;
            twos_reg <= 1'b1;
            randomizer_reg <= 1'b1;
            pattern_kind_reg <= serial_link_ctrl_pkg::KIND_NORMAL;
        end else begin
            sync_request_reg <= sync_request_next;
            block_reset_reg <= block_reset_next;
            clock_enable_reg <= clock_enable_next;
            twos_reg <= twos_next;
            randomizer_reg <= randomizer_next;
            pattern_kind_reg <= pattern_kind_next;
        end
    end

    // ----------------------------------------------------------------
    // Lane mapping, one mapper per link
    // ----------------------------------------------------------------

    // Both links share the same map bit
    // Upper map is only meaningful in modes of 8 lanes or fewer
    assign lanes_a.link_enable = link_enable;
    assign lanes_a.upper_lane_map = link_control_reg[serial_link_ctrl_pkg::POS_UPPER_LANES];
    assign lanes_b.link_enable = link_enable;
    assign lanes_b.upper_lane_map = link_control_reg[serial_link_ctrl_pkg::POS_UPPER_LANES];

    lane_mapper u_lanes_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .lanes(lanes_a)
    );

    lane_mapper u_lanes_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .lanes(lanes_b)
    );

    // Output assignments
    assign lane_power_a = lanes_a.lane_power;
    assign lane_power_b = lanes_b.lane_power;
    assign sync_request = sync_request_reg;
    assign link_block_reset = block_reset_reg;
    assign link_clock_enable = clock_enable_reg;
    assign sample_twos_complement = twos_reg;
    assign randomizer_active = randomizer_reg;
    assign link_pattern_select = link_test_select_reg[4:0];
    assign pattern_kind = pattern_kind_reg;
    assign clock_pattern_word = serial_link_ctrl_pkg::CLOCK_PATTERN_WORD;

endmodule

`default_nettype wire

// [bench/serial_link_ctrl_props.sv]
`timescale 1ns/1ps
`default_nettype none

module serial_link_ctrl_props (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Link controls
    input wire logic link_block_reset,
    input wire logic link_clock_enable,
    input wire logic [7:0] lane_power_a,
    input wire logic [7:0] lane_power_b,
    input wire logic sample_twos_complement,
    input wire logic randomizer_active,
    input wire logic [4:0] link_pattern_select,
    input wire logic [4:0] pattern_kind,
    input wire logic [15:0] clock_pattern_word
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Bus answers at once and never errors
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or error");
    a_upper_zero: assert property (hrdata[31:8] == 24'h000000) else $error("read upper bits set");
    // Read data changes only after a read is taken
    a_read_hold: assert property ($changed(hrdata)
        |-> $past(hsel && htrans[1] && !hwrite && hready))
        else $error("read data moved without read");
    // Disabled link stays in reset with clocks gated and lanes off
    a_clock_gate: assert property (link_clock_enable == !link_block_reset)
        else $error("clock enable disagrees with block reset");
    a_lanes_off: assert property (link_block_reset |->
        lane_power_a == 8'h00 && lane_power_b == 8'h00)
        else $error("lanes powered while disabled");
    // Enabled link uses one group of four lanes, same on both links
    a_lanes_group: assert property (!link_block_reset |->
        (lane_power_a == 8'h0f || lane_power_a == 8'hf0) && lane_power_b == lane_power_a)
        else $error("bad lane group");
    a_clock_word: assert property (clock_pattern_word == 16'h00ff)
        else $error("clock pattern word wrong");
    // Reserved codes and only those decode as undefined
    a_pattern_reserved: assert property (
        ($past(link_pattern_select) == 5'h0c || $past(link_pattern_select) > 5'h10)
        == (pattern_kind == 5'h10))
        else $error("reserved code decode wrong");
    // Select moves two edges, derived controls three edges after a write is taken
    a_select_hold: assert property ($changed(link_pattern_select)
        |-> $past(hsel && htrans[1] && hwrite && hready, 2))
        else $error("test select moved without write");
    a_outputs_hold: assert property ($changed(sample_twos_complement)
        || $changed(randomizer_active) |-> $past(hsel && htrans[1] && hwrite && hready, 3))
        else $error("control output moved without write");
endmodule

`default_nettype wire

// [bench/link_receiver_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Far-end receiver driving the active-low sync pins
module link_receiver_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Requests from the bench
    input wire logic want_sync,
    input wire logic want_stamp,
    // Pins
    output logic dedicated_sync_pin_n,
    output logic timestamp_pin_n
);
    // Pins low while a request is wanted, high when idle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dedicated_sync_pin_n <= 1'b1;
            timestamp_pin_n <= 1'b1;
        end else begin
            dedicated_sync_pin_n <= !want_sync;
            timestamp_pin_n <= !want_stamp;
        end
    end
endmodule

`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end

module tb_top;
    localparam logic [31:0] A_EN = 32'({serial_link_ctrl_pkg::IDX_LINK_ENABLE, 2'b00});
    localparam logic [31:0] A_SYNC = 32'({serial_link_ctrl_pkg::IDX_SW_SYNC, 2'b00});
    localparam logic [31:0] A_CTL = 32'({serial_link_ctrl_pkg::IDX_LINK_CONTROL, 2'b00});
    localparam logic [31:0] A_TST = 32'({serial_link_ctrl_pkg::IDX_TEST_SELECT, 2'b00});
    localparam logic [31:0] A_ENC = 32'({serial_link_ctrl_pkg::IDX_ENCODING, 2'b00});
    // Expected decoded kind for codes 0 to 16
    localparam logic [4:0] KIND_TAB [0:16] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h06, 5'h07, 5'h08,
        5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h10, 5'h02, 5'h05, 5'h0e, 5'h0f};
    logic hclk, hresetn, hsel, hwrite, want_sync, want_stamp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, ded_n, ts_n, sync_request, link_block_reset, link_clock_enable;
    logic sample_twos_complement, randomizer_active;
    logic [7:0] lane_power_a, lane_power_b;
    logic [4:0] link_pattern_select, pattern_kind;
    logic [15:0] clock_pattern_word;
    wire hready = hreadyout;
    int mismatches = 0;
    int tests_run = 0;

    serial_link_sync_lane_test_ctrl i_serial_link_sync_lane_test_ctrl (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .dedicated_sync_pin_n(ded_n), .timestamp_pin_n(ts_n),
        .sync_request(sync_request), .link_block_reset(link_block_reset),
        .link_clock_enable(link_clock_enable), .lane_power_a(lane_power_a),
        .lane_power_b(lane_power_b), .sample_twos_complement(sample_twos_complement),
        .randomizer_active(randomizer_active), .link_pattern_select(link_pattern_select),
        .pattern_kind(pattern_kind), .clock_pattern_word(clock_pattern_word));
    link_receiver_model i_link_receiver_model (.hclk(hclk), .hresetn(hresetn),
        .want_sync(want_sync), .want_stamp(want_stamp), .dedicated_sync_pin_n(ded_n),
        .timestamp_pin_n(ts_n));

    // -----------------------------------------------------------------
    // Bus tasks
    // -----------------------------------------------------------------
    task automatic bus_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus_xfer(1'b1, a, d);
    endtask
    task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
        bus_xfer(1'b0, a, 32'h00000000);
        `CHK("read data", e, rd)
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Clock of 100 ns period
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // Watchdog against a hung bus
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        give_verdict();
    end

    // -----------------------------------------------------------------
    // Tests
    // -----------------------------------------------------------------
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; hwdata = '0; want_sync = 1'b0; want_stamp = 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        settle(1);
        `CHK("lane_power_a", 8'h0f, lane_power_a)
        `CHK("sync_request", 1'b0, sync_request)
        `CHK("sample_twos_complement", 1'b1, sample_twos_complement)
        `CHK("randomizer_active", 1'b1, randomizer_active)
        chk_rd(A_SYNC, 32'(serial_link_ctrl_pkg::RST_SW_SYNC));
        chk_rd(A_CTL, 32'(serial_link_ctrl_pkg::RST_LINK_CONTROL));
        chk_rd(A_TST, 32'(serial_link_ctrl_pkg::RST_TEST_SELECT));
        wr(32'h00000900, 32'h5a); chk_rd(32'h00000900, 32'h0);
        chk_rd(32'h10000000 | A_CTL, 32'h0);
        $display("test reset_and_bus done");
        wr(A_EN, 32'h0);
        for (int s = 0; s < 4; s++) for (int p = 0; p < 4; p++) for (int w = 0; w < 2; w++) begin
            wr(A_CTL, 32'(s * 4 + 3)); wr(A_SYNC, 32'(w));
            want_sync <= p[0]; want_stamp <= p[1];
            settle(3);
            `CHK("sync_request", (w == 0) || (s == 0 && p[0]) || (s == 1 && p[1]),
                sync_request)
        end
        wr(A_SYNC, 32'h1); want_sync <= 1'b0; want_stamp <= 1'b0;
        $display("test sync_source done");
        for (int m = 0; m < 2; m++) begin
            wr(A_EN, 32'h0); wr(A_CTL, 32'(m * 16 + 3)); settle(2);
            `CHK("lane_power_a", 8'h00, lane_power_a)
            `CHK("link_block_reset", 1'b1, link_block_reset)
            `CHK("link_clock_enable", 1'b0, link_clock_enable)
            wr(A_EN, 32'h1); settle(2);
            `CHK("lane_power_a", m ? 8'hf0 : 8'h0f, lane_power_a)
            `CHK("lane_power_b", m ? 8'hf0 : 8'h0f, lane_power_b)
        end
        wr(A_EN, 32'h0);
        $display("test lane_map done");
        for (int v = 0; v < 4; v++) for (int e = 0; e < 2; e++) begin
            wr(A_CTL, 32'(v)); wr(A_ENC, 32'(e)); settle(2);
            `CHK("sample_twos_complement", v[1], sample_twos_complement)
            `CHK("randomizer_active", v[0] | e[0], randomizer_active)
        end
        $display("test format_randomizer done");
        wr(A_ENC, 32'h0);
        for (int c = 0; c < 32; c++) begin
            wr(A_TST, 32'(c)); settle(2);
            `CHK("link_pattern_select", 5'(c), link_pattern_select)
            `CHK("pattern_kind", c > 16 ? 5'h10 : KIND_TAB[c], pattern_kind)
            chk_rd(A_TST, 32'(c));
        end
        $display("test pattern_select done");
        wr(A_ENC, 32'h0); wr(A_CTL, 32'hffffffe3); settle(2);
        chk_rd(A_CTL, 32'h000000e3);
        `CHK("sample_twos_complement", 1'b1, sample_twos_complement)
        `CHK("randomizer_active", 1'b1, randomizer_active)
        wr(A_TST, 32'h000000e0); settle(2);
        `CHK("pattern_kind", 5'h00, pattern_kind)
        chk_rd(A_TST, 32'h000000e0);
        wr(A_SYNC, 32'h000000fe); settle(2);
        `CHK("sync_request", 1'b1, sync_request)
        chk_rd(32'h00000844, 32'h00000038);
        $display("test reserved_bits done");
        give_verdict();
    end
endmodule

bind serial_link_sync_lane_test_ctrl serial_link_ctrl_props i_serial_link_ctrl_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .link_block_reset(link_block_reset), .link_clock_enable(link_clock_enable),
    .lane_power_a(lane_power_a), .lane_power_b(lane_power_b),
    .sample_twos_complement(sample_twos_complement), .randomizer_active(randomizer_active),
    .link_pattern_select(link_pattern_select), .pattern_kind(pattern_kind),
    .clock_pattern_word(clock_pattern_word));

`default_nettype wire
